// *** src/dcmcd_top.sv ***
// Task-file command interpreter: transfer mode, block size, self-diagnosis
`timescale 1ns/1ps
`default_nettype none
`include "dcmcd_consts.svh"

// Operation
// (R01) Host loads feature 03h and a mode byte before the feature command.
// (R02) Mode byte: top five bits type, bottom three bits mode number.
// (R03) PIO mode 4 and multiword DMA mode 2 work without any selection; reset here selects PIO flow mode 4 only.
// (R04) Accept 00h as PIO default and 08h-0Ch as PIO flow modes 0-4.
// (R05) Accept 20h-22h as multiword DMA modes 0-2.
// (R06) Accept 40h-44h as Ultra DMA modes 0-4.
// (R07) Any other mode byte ends the command aborted.
// (R08) Block-size command C6h takes sector count; only 2, 4, 8, 16 valid.
// (R09) Block-size sets busy; valid count is stored and enables multi commands.
// (R10) Nonzero bad count aborts and disables multi commands.
// (R11) Zero count disables multi commands.
// (R12) Block-size completion clears busy and raises interrupt.
// (R13) Power-on or hardware reset leaves multi commands disabled.
// (R14) Software reset keeps multi enable and block count.
// (R15) Capability word reads 8010h.
// (R16) Current-setting word: 0000h disabled, else 01h and count.
// (R17) Diagnostic 90h runs on every device regardless of drive select.
// (R18) Master waits up to 5 s for the slave pass signal.
// (R19) Slave failure ORs 80h into the master diagnostic code.
// (R20) Only master clears busy and interrupts after diagnosis; here the slave also clears busy, only the interrupt is master-only.
// (R21) Codes: 01h pass, 03h buffer, 05h ROM, 8xh slave failure.
// (R22) Host may read slave status by selecting it.
// (R23) Feature command: busy, store parameters, clear busy, interrupt.
// (R24) Unsupported feature code aborts the command.
// (R25) After diagnosis: head and cylinders zero, sector regs 01h.
// (R26) Multi read or write while disabled aborts.
module dcmcd_top #(
	parameter int unsigned DIAG_WAIT_CYC = `DIAG_WAIT_S * `CLK_HZ
) (
	input wire logic CLK_SYS_I, // System clock
	input wire logic RESETN_I, // Hardware reset
	input wire logic CE_I, // Clock enable
	input wire logic SRST_I, // Software reset pulse
	input wire logic IS_SLAVE_I, // This unit is device 1
	input wire logic SLAVE_PRESENT_I, // Device 1 attached
	input wire logic [9:0] ADDR_I, // Task-file address
	input wire logic WR_I, // Write strobe
	input wire logic RD_I, // Read strobe
	input wire logic [7:0] WDATA_I, // Write data
	output logic [7:0] RDATA_O, // Read data
	output logic INTRQ_O, // Host interrupt
	output logic SELFTEST_REQ_O, // Start own self-test
	input wire logic SELFTEST_DONE_I, // Self-test finished
	input wire logic [7:0] SELFTEST_CODE_I, // Self-test code
	input wire logic PDIAG_N_I, // Pass-diagnostic pin in
	output logic PDIAG_N_O, // Pass-diagnostic pin out
	output logic PDIAG_OE_O, // Pass-diagnostic drive
	output logic MULT_EN_O, // Multi commands enabled
	output logic [7:0] MULT_CNT_O, // Sectors per block
	output logic MULT_GO_O, // Multi transfer start
	output logic [4:0] XFER_TYPE_O, // Transfer type
	output logic [2:0] XFER_MODE_O, // Transfer mode number
	output logic [15:0] ID_W47_O, // Multi capability word
	output logic [15:0] ID_W59_O // Multi setting word
);
	if (DIAG_WAIT_CYC < 2) begin : g_chk
		$error("DIAG_WAIT_CYC too small");
	end

	dcmcd_pkg::dcmcd_state_t st_q;
	logic [7:0] opc_q, feat_q, sc_q, sn_q, cl_q, ch_q, dh_q, err_q;
	logic bsy_q, abort_q, intrq_q, mult_en_q, diag_slv_q;
	logic [7:0] mult_cnt_q, diag_code_q;
	logic [31:0] wait_q;
	logic tf_wr, cmd_wr, sel_me, in_exec, in_done, mode_ok, blk_ok, exec_abort;
	logic st_rd, wait_end;

	// ************************************************
	// Decode
	// ************************************************
	function automatic logic chk_mode(input logic [7:0] b);
		logic [4:0] ty;
		logic [2:0] md;
		ty = b[7:3];
		md = b[2:0];
		case (ty)
			`TY_PIO_DEF: chk_mode = (md <= `MX_PIO_DEF); // R04
			`TY_PIO_FC: chk_mode = (md <= `MX_PIO_FC); // R04
			`TY_MDMA: chk_mode = (md <= `MX_MDMA); // R05
			`TY_UDMA: chk_mode = (md <= `MX_UDMA); // R06
			default: chk_mode = 1'b0; // R07
		endcase
	endfunction

	assign sel_me = (dh_q[`DRV_BIT] == IS_SLAVE_I);
	assign tf_wr = CE_I & WR_I & ~bsy_q;
	// Diagnostic is taken whatever drive select holds
	assign cmd_wr = tf_wr & (ADDR_I == `A_CMD) & (sel_me | (WDATA_I == `OP_DIAG)); // R17
	assign st_rd = CE_I & RD_I & (ADDR_I == `A_CMD);
	assign in_exec = (st_q == dcmcd_pkg::DCMCD_EXEC);
	assign in_done = (st_q == dcmcd_pkg::DCMCD_DONE);
	assign mode_ok = chk_mode(sc_q); // R02
	assign blk_ok = (sc_q == `BLK_2) | (sc_q == `BLK_4) | (sc_q == `BLK_8) | (sc_q == `BLK_16); // R08
	assign wait_end = (wait_q == DIAG_WAIT_CYC - 32'd1);

	always_comb begin
		case (opc_q)
			`OP_FEAT: exec_abort = ~((feat_q == `FEAT_XFER) & mode_ok); // R07 R24
			`OP_MULT: exec_abort = (sc_q != `BYTE_ZERO) & ~blk_ok; // R10
			`OP_DIAG: exec_abort = 1'b0;
			`OP_RDM, `OP_WRM: exec_abort = ~mult_en_q; // R26
			default: exec_abort = 1'b1;
		endcase
	end

	// ************************************************
	// Sequencer
	// ************************************************
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_q <= dcmcd_pkg::DCMCD_IDLE;
			opc_q <= `BYTE_ZERO;
			bsy_q <= 1'b0;
			abort_q <= 1'b0;
			wait_q <= '0;
		end else if (CE_I) begin
			if (SRST_I) begin
				st_q <= dcmcd_pkg::DCMCD_IDLE;
				bsy_q <= 1'b0;
				abort_q <= 1'b0;
			end else begin
				case (st_q)
					dcmcd_pkg::DCMCD_IDLE: begin
						if (cmd_wr) begin
							opc_q <= WDATA_I;
							bsy_q <= 1'b1; // R09 R23
							abort_q <= 1'b0;
							st_q <= dcmcd_pkg::DCMCD_EXEC;
						end
					end
					dcmcd_pkg::DCMCD_EXEC: begin
						abort_q <= exec_abort;
						if (opc_q == `OP_DIAG) begin
							st_q <= dcmcd_pkg::DCMCD_DSELF;
						end else begin
							st_q <= dcmcd_pkg::DCMCD_DONE;
						end
					end
					dcmcd_pkg::DCMCD_DSELF: begin
						wait_q <= '0;
						if (SELFTEST_DONE_I) begin
							if (!IS_SLAVE_I && SLAVE_PRESENT_I) begin
								st_q <= dcmcd_pkg::DCMCD_DWAIT;
							end else begin
								st_q <= dcmcd_pkg::DCMCD_DONE;
							end
						end
					end
					dcmcd_pkg::DCMCD_DWAIT: begin
						wait_q <= wait_q + 32'd1;
						// Bounded wait, slave silence counts as failure
						if (!PDIAG_N_I || wait_end) begin // R18
							st_q <= dcmcd_pkg::DCMCD_DONE;
						end
					end
					dcmcd_pkg::DCMCD_DONE: begin
						bsy_q <= 1'b0; // R12 R20 R23
						st_q <= dcmcd_pkg::DCMCD_IDLE;
					end
					default: st_q <= dcmcd_pkg::DCMCD_IDLE;
				endcase
			end
		end
	end

	// ************************************************
	// Task-file registers
	// ************************************************
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			feat_q <= `BYTE_ZERO;
			sc_q <= `TF_ONE;
			sn_q <= `TF_ONE;
			cl_q <= `BYTE_ZERO;
			ch_q <= `BYTE_ZERO;
			dh_q <= `BYTE_ZERO;
		end else if (CE_I) begin
			if (in_done && opc_q == `OP_DIAG) begin
				sc_q <= `TF_ONE; // R25
				sn_q <= `TF_ONE; // R25
				cl_q <= `BYTE_ZERO; // R25
				ch_q <= `BYTE_ZERO; // R25
				dh_q <= `BYTE_ZERO; // R25
			end else if (tf_wr) begin
				case (ADDR_I)
					`A_ERR: feat_q <= WDATA_I;
					`A_SCNT: sc_q <= WDATA_I;
					`A_SNUM: sn_q <= WDATA_I;
					`A_CYLL: cl_q <= WDATA_I;
					`A_CYLH: ch_q <= WDATA_I;
					`A_DRVH: dh_q <= WDATA_I;
					default: ;
				endcase
			end
		end
	end

	// ************************************************
	// Stored modes
	// ************************************************
	// Block setting has no software-reset branch on purpose
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mult_en_q <= 1'b0; // R13
			mult_cnt_q <= `BYTE_ZERO;
		end else if (CE_I && !SRST_I && in_exec && opc_q == `OP_MULT) begin // R14
			mult_en_q <= blk_ok; // R09 R10 R11
			if (blk_ok) begin
				mult_cnt_q <= sc_q; // R09
			end
		end
	end

	// Reset value serves the PIO 4 timing only (flow type, mode 4); MDMA 2 is not selected
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			XFER_TYPE_O <= `XFER_RST_TY; // R03
			XFER_MODE_O <= `XFER_RST_MD; // R03
		end else if (CE_I && in_exec && opc_q == `OP_FEAT && !exec_abort) begin
			XFER_TYPE_O <= sc_q[7:3]; // R02 R23
			XFER_MODE_O <= sc_q[2:0]; // R02
		end
	end

	// ************************************************
	// Diagnosis
	// ************************************************
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			diag_code_q <= `TF_ONE;
			diag_slv_q <= 1'b0;
			SELFTEST_REQ_O <= 1'b0;
			PDIAG_OE_O <= 1'b0;
		end else if (CE_I) begin
			SELFTEST_REQ_O <= in_exec && opc_q == `OP_DIAG && !SRST_I; // R17
			diag_slv_q <= 1'b0;
			if (cmd_wr || SRST_I) begin
				PDIAG_OE_O <= 1'b0;
			end
			if (st_q == dcmcd_pkg::DCMCD_DSELF && SELFTEST_DONE_I) begin
				diag_code_q <= SELFTEST_CODE_I; // R21
				// Slave reports a pass to the master by pulling the pin
				PDIAG_OE_O <= IS_SLAVE_I && SELFTEST_CODE_I == `TF_ONE;
			end
			if (st_q == dcmcd_pkg::DCMCD_DWAIT && PDIAG_N_I && wait_end) begin
				diag_code_q <= diag_code_q | `DIAG_SLV_FAIL; // R19
				diag_slv_q <= 1'b1;
			end
		end
	end

	// ************************************************
	// Completion
	// ************************************************
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			err_q <= `BYTE_ZERO;
			intrq_q <= 1'b0;
			MULT_GO_O <= 1'b0;
		end else if (CE_I) begin
			MULT_GO_O <= in_exec && !exec_abort && !SRST_I &&
				(opc_q == `OP_RDM || opc_q == `OP_WRM);
			if (in_done && !SRST_I) begin
				err_q <= (opc_q == `OP_DIAG) ? diag_code_q : (abort_q ? `ERR_ABRT : `BYTE_ZERO);
			end
			// Completion wins over a clearing status read
			if (in_done && !SRST_I && !(opc_q == `OP_DIAG && IS_SLAVE_I)) begin
				intrq_q <= 1'b1; // R12 R20 R23
			end else if (st_rd || cmd_wr || SRST_I) begin
				intrq_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			RDATA_O <= `BYTE_ZERO;
			ID_W47_O <= `ID47_VAL;
			ID_W59_O <= `ID59_OFF;
		end else if (CE_I) begin
			ID_W47_O <= `ID47_VAL; // R15
			ID_W59_O <= mult_en_q ? {`ID59_EN, mult_cnt_q} : `ID59_OFF; // R16
			if (RD_I) begin
				case (ADDR_I)
					`A_ERR: RDATA_O <= err_q;
					`A_SCNT: RDATA_O <= sc_q;
					`A_SNUM: RDATA_O <= sn_q;
					`A_CYLL: RDATA_O <= cl_q;
					`A_CYLH: RDATA_O <= ch_q;
					`A_DRVH: RDATA_O <= dh_q;
					`A_CMD: begin
						RDATA_O <= `BYTE_ZERO;
						RDATA_O[`ST_BSY] <= bsy_q;
						RDATA_O[`ST_DRDY] <= ~bsy_q;
						RDATA_O[`ST_ERR] <= abort_q;
					end
					default: RDATA_O <= `BYTE_ZERO;
				endcase
			end
		end
	end

	assign INTRQ_O = intrq_q;
	assign MULT_EN_O = mult_en_q;
	assign MULT_CNT_O = mult_cnt_q;
	assign PDIAG_N_O = 1'b0;

	// ************************************************
	// Assertions
	// ************************************************
	property p_mode_abort;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		CE_I && !SRST_I && in_exec && opc_q == `OP_FEAT && !mode_ok |=> abort_q;
	endproperty
	a_mode_abort: assert property (p_mode_abort) else $error("bad mode not aborted"); // R07

	property p_mode_store;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		CE_I && in_exec && opc_q == `OP_FEAT && feat_q == `FEAT_XFER && mode_ok
		|=> {XFER_TYPE_O, XFER_MODE_O} == $past(sc_q) && !abort_q;
	endproperty
	a_mode_store: assert property (p_mode_store) else $error("mode not stored"); // R02

	property p_blk_store;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		CE_I && !SRST_I && in_exec && opc_q == `OP_MULT && blk_ok
		|=> mult_en_q && mult_cnt_q == $past(sc_q) ##2 ID_W59_O == {`ID59_EN, $past(sc_q, 3)};
	endproperty
	a_blk_store: assert property (p_blk_store) else $error("block count not stored"); // R09

	property p_blk_bad;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		CE_I && !SRST_I && in_exec && opc_q == `OP_MULT && sc_q != `BYTE_ZERO && !blk_ok
		|=> !mult_en_q && abort_q;
	endproperty
	a_blk_bad: assert property (p_blk_bad) else $error("bad count accepted"); // R10

	property p_blk_zero;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		CE_I && !SRST_I && in_exec && opc_q == `OP_MULT && sc_q == `BYTE_ZERO
		|=> !mult_en_q && !abort_q;
	endproperty
	a_blk_zero: assert property (p_blk_zero) else $error("zero count mishandled"); // R11

	property p_done_irq;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		CE_I && !SRST_I && in_exec && opc_q != `OP_DIAG
		|=> in_done ##1 (INTRQ_O && !bsy_q);
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("no completion interrupt"); // R12

	property p_srst_keep;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		SRST_I |=> $stable(mult_en_q) && $stable(mult_cnt_q);
	endproperty
	a_srst_keep: assert property (p_srst_keep) else $error("soft reset lost setting"); // R14

	property p_slave_fail;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		CE_I && !SRST_I && st_q == dcmcd_pkg::DCMCD_DWAIT && PDIAG_N_I && wait_end
		|=> in_done && diag_code_q[7] ##1 err_q[7] && INTRQ_O;
	endproperty
	a_slave_fail: assert property (p_slave_fail) else $error("slave failure not flagged"); // R19

	property p_slave_quiet;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		CE_I && in_done && opc_q == `OP_DIAG && IS_SLAVE_I && !INTRQ_O |=> !INTRQ_O;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet) else $error("slave interrupted"); // R20

	property p_diag_regs;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		CE_I && in_done && opc_q == `OP_DIAG
		|=> sc_q == `TF_ONE && sn_q == `TF_ONE && dh_q == `BYTE_ZERO && ch_q == `BYTE_ZERO;
	endproperty
	a_diag_regs: assert property (p_diag_regs) else $error("diag registers wrong"); // R25

	property p_multi_reject;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		CE_I && !SRST_I && in_exec && (opc_q == `OP_RDM || opc_q == `OP_WRM) && !mult_en_q
		|=> abort_q && !MULT_GO_O;
	endproperty
	a_multi_reject: assert property (p_multi_reject) else $error("multi not rejected"); // R26

	c_slave_fail: cover property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		st_q == dcmcd_pkg::DCMCD_DWAIT && wait_end && PDIAG_N_I);
	c_blk_ok: cover property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		in_exec && opc_q == `OP_MULT && blk_ok);
	c_mode_ok: cover property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		in_exec && opc_q == `OP_FEAT && !exec_abort);
endmodule // dcmcd_top
`default_nettype wire

// *** pkg/dcmcd_consts.svh ***
// Constants of the disk command, mode, configuration and diagnosis block
`ifndef DCMCD_CONSTS_SVH
`define DCMCD_CONSTS_SVH
`define A_ERR 10'h1f1
`define A_SCNT 10'h1f2
`define A_SNUM 10'h1f3
`define A_CYLL 10'h1f4
`define A_CYLH 10'h1f5
`define A_DRVH 10'h1f6
`define A_CMD 10'h1f7
`define OP_FEAT 8'hef
`define OP_MULT 8'hc6
`define OP_DIAG 8'h90
`define OP_RDM 8'hc4
`define OP_WRM 8'hc5
`define FEAT_XFER 8'h03
`define TY_PIO_DEF 5'h00
`define TY_PIO_FC 5'h01
`define TY_MDMA 5'h04
`define TY_UDMA 5'h08
`define MX_PIO_DEF 3'h0
`define MX_PIO_FC 3'h4
`define MX_MDMA 3'h2
`define MX_UDMA 3'h4
`define XFER_RST_TY 5'h01
`define XFER_RST_MD 3'h4
`define BLK_2 8'h02
`define BLK_4 8'h04
`define BLK_8 8'h08
`define BLK_16 8'h10
`define BYTE_ZERO 8'h00
`define TF_ONE 8'h01
`define ERR_ABRT 8'h04
`define DIAG_SLV_FAIL 8'h80
`define ST_BSY 7
`define ST_DRDY 6
`define ST_ERR 0
`define DRV_BIT 4
`define ID47_VAL 16'h8010
`define ID59_EN 8'h01
`define ID59_OFF 16'h0000
`define DIAG_WAIT_S 32'd5
`define CLK_HZ 32'd100000000
`endif

// *** pkg/dcmcd_pkg.sv ***
// Types of the disk command, mode, configuration and diagnosis block
package dcmcd_pkg;
	typedef enum logic [2:0] {
		DCMCD_IDLE = 3'h0,
		DCMCD_EXEC = 3'h1,
		DCMCD_DSELF = 3'h3,
		DCMCD_DWAIT = 3'h2,
		DCMCD_DONE = 3'h6
	} dcmcd_state_t;
endpackage

// *** verif/dcmcd_host_model.sv ***
// Host controller model driving the task-file strobes
`timescale 1ns/1ps
`default_nettype none
`include "dcmcd_consts.svh"
module dcmcd_host_model (
	input wire logic clk_i, // System clock
	input wire logic [7:0] rdata_i, // Read data from device
	output logic [9:0] addr_o, // Task-file address
	output logic wr_o, // Write strobe
	output logic rd_o, // Read strobe
	output logic [7:0] wdata_o // Write data
);
	initial begin
		addr_o = 10'h000;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end
	// ****************************************
	// Bus cycles, launched on the falling edge
	// ****************************************
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		// Released data flips so a stale byte never looks valid
		wdata_o = ~d;
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		@(negedge clk_i);
		d = rdata_i;
	endtask
	task automatic set_xfer(input logic [7:0] f, input logic [7:0] m);
		wr(`A_ERR, f);
		wr(`A_SCNT, m);
	endtask
	task automatic select(input logic dev);
		wr(`A_DRVH, {3'h0, dev, 4'h0});
	endtask
endmodule // dcmcd_host_model
`default_nettype wire

// *** verif/disk_cmd_mode_config_diag_test.sv ***
// Self-checking bench of the task-file command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "dcmcd_consts.svh"
module disk_cmd_mode_config_diag_test;
	logic clk, rst_n, srst, is_slave, slave_pres, wr, rd, intrq, st_req, st_done;
	logic pdiag_n, pdiag_oe, mult_en, mult_go, peer_pull, ce, pdiag_o;
	logic [9:0] addr;
	logic [7:0] wdata, rdata, st_code, mult_cnt;
	logic [4:0] xfer_ty;
	logic [2:0] xfer_md;
	logic [15:0] id47, id59;
	int miscompares = 0;
	int n_tests = 0;
	int go_cnt = 0;
	int st_cnt = 0;
	logic [7:0] good[14] = '{8'h00, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h20, 8'h21,
		8'h22, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44};
	logic [7:0] bad[8] = '{8'h01, 8'h07, 8'h0d, 8'h10, 8'h23, 8'h24, 8'h45, 8'hff};
	logic [7:0] blk[4] = '{`BLK_2, `BLK_4, `BLK_8, `BLK_16};
	logic [7:0] codes[3] = '{8'h01, 8'h03, 8'h05};
	logic [9:0] regs[5] = '{`A_SCNT, `A_SNUM, `A_CYLL, `A_CYLH, `A_DRVH};
	logic [7:0] after[5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
	// Pull-up on the pass wire; either unit may pull it low
	assign pdiag_n = (pdiag_oe || peer_pull) ? 1'b0 : 1'b1;
	dcmcd_top #(.DIAG_WAIT_CYC(20)) uut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .CE_I(ce),
		.SRST_I(srst), .IS_SLAVE_I(is_slave), .SLAVE_PRESENT_I(slave_pres), .ADDR_I(addr),
		.WR_I(wr), .RD_I(rd), .WDATA_I(wdata), .RDATA_O(rdata), .INTRQ_O(intrq),
		.SELFTEST_REQ_O(st_req), .SELFTEST_DONE_I(st_done), .SELFTEST_CODE_I(st_code),
		.PDIAG_N_I(pdiag_n), .PDIAG_N_O(pdiag_o), .PDIAG_OE_O(pdiag_oe), .MULT_EN_O(mult_en),
		.MULT_CNT_O(mult_cnt), .MULT_GO_O(mult_go), .XFER_TYPE_O(xfer_ty),
		.XFER_MODE_O(xfer_md), .ID_W47_O(id47), .ID_W59_O(id59));
	dcmcd_host_model host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
		.rd_o(rd), .wdata_o(wdata));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Self-test engine answers four cycles after its start pulse
	always @(negedge clk) begin
		st_done <= (st_cnt == 1);
		if (st_req === 1'b1) st_cnt <= 4;
		else if (st_cnt != 0) st_cnt <= st_cnt - 1;
	end
	always @(posedge clk) if (mult_go === 1'b1) go_cnt++;
	// ****************************************
	// Shared helpers
	// ****************************************
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			miscompares++;
		end
	endtask
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic hw_reset();
		@(negedge clk);
		rst_n = 1'b0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
	endtask
	task automatic run(input logic [7:0] op, input logic irq, output logic [7:0] st);
		int n;
		host.wr(`A_CMD, op);
		n = 0;
		while (intrq !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk(intrq, irq);
		host.rd(`A_CMD, st);
		chk(st[`ST_BSY], 1'b0);
	endtask
	task automatic reg_chk(input logic [9:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk(d, e);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_power();
		logic [7:0] s;
		chk(xfer_ty, `XFER_RST_TY);
		chk(xfer_md, `XFER_RST_MD);
		chk(mult_en, 1'b0);
		chk(id47, `ID47_VAL);
		chk(id59, `ID59_OFF);
		// Write with clock enable low must be dropped
		ce = 1'b0;
		host.wr(`A_SCNT, 8'h5a);
		ce = 1'b1;
		reg_chk(`A_SCNT, `TF_ONE);
		run(`OP_WRM, 1'b1, s);
		chk(s[`ST_ERR], 1'b1);
		reg_chk(`A_ERR, `ERR_ABRT);
	endtask
	task automatic t_xfer();
		logic [7:0] s;
		foreach (good[i]) begin
			host.set_xfer(`FEAT_XFER, good[i]);
			run(`OP_FEAT, 1'b1, s);
			chk(s[`ST_ERR], 1'b0);
			chk(xfer_ty, good[i][7:3]);
			chk(xfer_md, good[i][2:0]);
		end
		foreach (bad[i]) begin
			host.set_xfer(`FEAT_XFER, bad[i]);
			run(`OP_FEAT, 1'b1, s);
			chk(s[`ST_ERR], 1'b1);
			chk({xfer_ty, xfer_md}, 8'h44);
		end
		host.set_xfer(8'h02, 8'h00);
		run(`OP_FEAT, 1'b1, s);
		reg_chk(`A_ERR, `ERR_ABRT);
	endtask
	task automatic t_mult();
		logic [7:0] s;
		int n;
		foreach (blk[i]) begin
			host.wr(`A_SCNT, blk[i]);
			run(`OP_MULT, 1'b1, s);
			chk(s[`ST_ERR], 1'b0);
			chk(mult_en, 1'b1);
			chk(mult_cnt, blk[i]);
			chk(id59, {`ID59_EN, blk[i]});
			n = go_cnt;
			run(`OP_RDM, 1'b1, s);
			chk(16'(go_cnt), 16'(n + 1));
		end
		host.wr(`A_SCNT, 8'h03);
		run(`OP_MULT, 1'b1, s);
		chk(s[`ST_ERR], 1'b1);
		chk(mult_en, 1'b0);
		host.wr(`A_SCNT, `BLK_8);
		run(`OP_MULT, 1'b1, s);
		host.wr(`A_SCNT, 8'h00);
		run(`OP_MULT, 1'b1, s);
		chk(mult_en, 1'b0);
		chk(id59, `ID59_OFF);
		host.wr(`A_SCNT, `BLK_16);
		run(`OP_MULT, 1'b1, s);
		@(negedge clk);
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		chk({mult_en, mult_cnt}, 9'h110);
		hw_reset();
		chk(mult_en, 1'b0);
		chk(id59, `ID59_OFF);
	endtask
	task automatic t_diag_one(input logic pres, input logic pull, input logic [7:0] c,
		input logic [7:0] e);
		logic [7:0] s;
		host.select(1'b1);
		foreach (regs[i]) if (i < 4) host.wr(regs[i], 8'h5a);
		slave_pres = pres;
		peer_pull = pull;
		st_code = c;
		run(`OP_DIAG, 1'b1, s);
		reg_chk(`A_ERR, e);
		foreach (regs[i]) reg_chk(regs[i], after[i]);
		peer_pull = 1'b0;
	endtask
	task automatic t_diag();
		foreach (codes[i]) t_diag_one(1'b0, 1'b0, codes[i], codes[i]);
		t_diag_one(1'b1, 1'b0, 8'h01, 8'h81);
		t_diag_one(1'b1, 1'b1, 8'h01, 8'h01);
	endtask
	task automatic t_slave();
		logic [7:0] s;
		is_slave = 1'b1;
		st_code = 8'h01;
		run(`OP_DIAG, 1'b0, s);
		chk(pdiag_oe, 1'b1);
		chk(pdiag_o, 1'b0);
		host.select(1'b1);
		reg_chk(`A_ERR, 8'h01);
		st_code = 8'h05;
		run(`OP_DIAG, 1'b0, s);
		chk(pdiag_oe, 1'b0);
		reg_chk(`A_ERR, 8'h05);
		is_slave = 1'b0;
	endtask
	initial begin
		rst_n = 1'b0;
		srst = 1'b0;
		is_slave = 1'b0;
		slave_pres = 1'b0;
		peer_pull = 1'b0;
		ce = 1'b1;
		st_code = 8'h01;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		t_power();
		t_xfer();
		t_mult();
		t_diag();
		t_slave();
		conclude();
	end
	// Under a thousand cycles expected; forty thousand cycles is a hang
	initial begin
		#400000;
		miscompares++;
		conclude();
	end
endmodule // disk_cmd_mode_config_diag_test
`default_nettype wire
